// [rtl/gp_timer_irq_mask.sv]
// Notes on behaviour
// - trigger bits 7:5 pick start source: command only, rx end, rx start; 4-7 unused.
// - code three starts on tx end in nfc mode; expiry of a run started by that tx end switches field off.
// - control bit 1 puts the no-response timer into payment-compliance mode.
// - control bit 0 picks no-response step: 64 or 4096 carrier periods.
// - 16-bit general timeout from high and low bytes, 8 carrier periods per count.
// - all fields return to defaults at power-up and on set-default command.
// - main mask bits 7..2 suppress matching main interrupts; bits 1,0 unused.
// - timer/field mask bits 7..0 suppress their matching interrupts.
// - general timer expiry raises its own timer/field flag unless masked.
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module gp_timer_irq_mask
    import gpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic set_default_i,
    input wire logic carrier_i,
    input wire timer_ev_t ev_i,
    input wire logic nrt_restart_i,
    input wire logic [7:0] main_src_i,
    input wire logic [7:0] tf_src_i,
    output logic [7:0] rdata_o,
    output logic gpt_running_o,
    output logic gpt_expire_o,
    output logic field_off_o,
    output logic nrt_emv_o,
    output logic nrt_step_o,
    output logic [7:0] main_irq_o,
    output logic [7:0] tf_irq_o,
    output logic irq_o
);
    top_state_t st_r;
    top_state_t st_nxt;
    logic fc_tick;
    logic gpt_tick;
    logic gpt_start;
    logic [2:0] trig_code;
    logic [15:0] gpt_value;
    logic trig_hit;
    logic [12:0] nrt_div;

    // carrier arrives from a pin, so it is synchronised first
    carrier_sync u_carrier_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(carrier_i),
        .rise_o(fc_tick)
    );

    // general timer prescaler, restarted with each timer start
    step_divider #(.DW(STEP_DIV_W)) u_gpt_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(fc_tick),
        .restart_i(gpt_start),
        .div_i(GPT_STEP_FC),
        .step_o(gpt_tick)
    );

    // no-response step select
    assign nrt_div = st_r.trig_ctrl[NRT_STEP_BIT] ? NRT_STEP_LONG_FC
                                                  : NRT_STEP_SHORT_FC;

    // no-response step enable handed to the neighbouring timer
    step_divider #(.DW(STEP_DIV_W)) u_nrt_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(fc_tick),
        .restart_i(nrt_restart_i),
        .div_i(nrt_div),
        .step_o(nrt_step_o)
    );

    // trigger decode; unused codes never fire
    always_comb begin
        trig_code = st_r.trig_ctrl[TRIG_MSB:TRIG_LSB];
        unique case (trig_code)
            TRIG_RX_END: trig_hit = ev_i.rx_end;
            TRIG_RX_START: trig_hit = ev_i.rx_start;
            TRIG_TX_END_NFC: trig_hit = ev_i.tx_end & ev_i.nfc_mode;
            default: trig_hit = 1'b0;
        endcase
    end

    // a zero timeout would wrap and run 65536 counts, so it does not start
    assign gpt_value = {st_r.gpt_hi, st_r.gpt_lo};
    assign gpt_start = (ev_i.start_cmd | trig_hit) & (gpt_value != 16'h0000)
                       & ~set_default_i;

    always_comb begin
        st_nxt = st_r;
        st_nxt.gpt_expire = 1'b0;
        st_nxt.field_off = 1'b0;
        st_nxt.rdata = 8'h00;

        // register writes; reserved bits are dropped
        if (wr_i) begin
            unique case (addr_i)
                ADDR_TRIG_CTRL: st_nxt.trig_ctrl = wdata_i & TRIG_CTRL_USED;
                ADDR_GPT_HI: st_nxt.gpt_hi = wdata_i;
                ADDR_GPT_LO: st_nxt.gpt_lo = wdata_i;
                ADDR_MAIN_MASK: st_nxt.main_mask = wdata_i & MAIN_MASK_USED;
                ADDR_TF_MASK: st_nxt.tf_mask = wdata_i;
                default: ;
            endcase
        end

        // read data stands for one cycle only
        if (rd_i) begin
            unique case (addr_i)
                ADDR_TRIG_CTRL: st_nxt.rdata = st_r.trig_ctrl;
                ADDR_GPT_HI: st_nxt.rdata = st_r.gpt_hi;
                ADDR_GPT_LO: st_nxt.rdata = st_r.gpt_lo;
                ADDR_MAIN_MASK: st_nxt.rdata = st_r.main_mask;
                ADDR_TF_MASK: st_nxt.rdata = st_r.tf_mask;
                ADDR_STATUS: begin
                    st_nxt.rdata[STAT_RUN_BIT] = (st_r.gpt_state == GPT_RUN);
                    st_nxt.rdata[STAT_ARM_BIT] = st_r.field_arm;
                end
                default: st_nxt.rdata = 8'h00;
            endcase
        end

        // general timer: a new start reloads even while running
        unique case (st_r.gpt_state)
            GPT_IDLE: begin
                if (gpt_start) begin
                    st_nxt.gpt_state = GPT_RUN;
                    st_nxt.gpt_count = gpt_value;
                    st_nxt.field_arm = trig_hit & (trig_code == TRIG_TX_END_NFC);
                end
            end
            GPT_RUN: begin
                if (gpt_start) begin
                    st_nxt.gpt_count = gpt_value;
                    st_nxt.field_arm = trig_hit & (trig_code == TRIG_TX_END_NFC);
                end else if (gpt_tick) begin
                    if (st_r.gpt_count == 16'h0001) begin
                        st_nxt.gpt_state = GPT_IDLE;
                        st_nxt.gpt_expire = 1'b1;
                        st_nxt.field_off = st_r.field_arm;
                        st_nxt.field_arm = 1'b0;
                    end else begin
                        st_nxt.gpt_count = st_r.gpt_count - 16'h0001;
                    end
                end
            end
        endcase

        // masked requests: masks touch nothing but these outputs
        st_nxt.main_irq = main_src_i & MAIN_MASK_USED & ~st_r.main_mask;
        st_nxt.tf_irq = tf_src_i & ~st_r.tf_mask;
        st_nxt.tf_irq[TF_GPE_BIT] = st_r.gpt_expire & ~st_r.tf_mask[TF_GPE_BIT];
        st_nxt.irq = (|st_nxt.main_irq) | (|st_nxt.tf_irq);

        // set-default beats a write in the same cycle and stops the timer
        if (set_default_i) begin
            st_nxt.trig_ctrl = RST_TRIG_CTRL;
            st_nxt.gpt_hi = RST_GPT_HI;
            st_nxt.gpt_lo = RST_GPT_LO;
            st_nxt.main_mask = RST_MAIN_MASK;
            st_nxt.tf_mask = RST_TF_MASK;
            st_nxt.gpt_state = GPT_IDLE;
            st_nxt.gpt_count = 16'h0000;
            st_nxt.field_arm = 1'b0;
        end
    end

    // power-up defaults
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.trig_ctrl <= RST_TRIG_CTRL;
            st_r.gpt_hi <= RST_GPT_HI;
            st_r.gpt_lo <= RST_GPT_LO;
            st_r.main_mask <= RST_MAIN_MASK;
            st_r.tf_mask <= RST_TF_MASK;
            st_r.gpt_state <= GPT_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    assign rdata_o = st_r.rdata;
    assign gpt_running_o = (st_r.gpt_state == GPT_RUN);
    assign gpt_expire_o = st_r.gpt_expire;
    assign field_off_o = st_r.field_off;
    assign nrt_emv_o = st_r.trig_ctrl[NRT_EMV_BIT];
    assign main_irq_o = st_r.main_irq;
    assign tf_irq_o = st_r.tf_irq;
    assign irq_o = st_r.irq;
endmodule // gp_timer_irq_mask
`default_nettype wire

// [shared/gpt_pkg.sv]
package gpt_pkg;

    // register addresses on the plain register port
    localparam logic [7:0] ADDR_TRIG_CTRL = 8'h11;
    localparam logic [7:0] ADDR_GPT_HI = 8'h12;
    localparam logic [7:0] ADDR_GPT_LO = 8'h13;
    localparam logic [7:0] ADDR_MAIN_MASK = 8'h14;
    localparam logic [7:0] ADDR_TF_MASK = 8'h15;
    localparam logic [7:0] ADDR_STATUS = 8'h1f;

    // values after reset and after the set-default command
    localparam logic [7:0] RST_TRIG_CTRL = 8'h00;
    localparam logic [7:0] RST_GPT_HI = 8'h00;
    localparam logic [7:0] RST_GPT_LO = 8'h00;
    localparam logic [7:0] RST_MAIN_MASK = 8'h00;
    localparam logic [7:0] RST_TF_MASK = 8'h00;

    // field positions
    localparam int TRIG_MSB = 7;
    localparam int TRIG_LSB = 5;
    localparam int NRT_EMV_BIT = 1;
    localparam int NRT_STEP_BIT = 0;
    localparam int TF_GPE_BIT = 5;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_ARM_BIT = 1;

    // writable bits; the rest read as zero
    localparam logic [7:0] TRIG_CTRL_USED = 8'he3;
    localparam logic [7:0] MAIN_MASK_USED = 8'hfc;

    // trigger source codes
    localparam logic [2:0] TRIG_CMD_ONLY = 3'h0;
    localparam logic [2:0] TRIG_RX_END = 3'h1;
    localparam logic [2:0] TRIG_RX_START = 3'h2;
    localparam logic [2:0] TRIG_TX_END_NFC = 3'h3;

    // step sizes in carrier periods
    localparam int STEP_DIV_W = 13;
    localparam logic [12:0] GPT_STEP_FC = 13'h0008;
    localparam logic [12:0] NRT_STEP_SHORT_FC = 13'h0040;
    localparam logic [12:0] NRT_STEP_LONG_FC = 13'h1000;

    // timer start events, one-cycle pulses on clk_i except nfc_mode, which is a level
    typedef struct packed {
        logic start_cmd;
        logic rx_start;
        logic rx_end;
        logic tx_end;
        logic nfc_mode;
    } timer_ev_t;

    typedef enum logic [0:0] {GPT_IDLE, GPT_RUN} gpt_state_t;

    typedef struct packed {
        logic [2:0] shift;
        logic level;
        logic rise;
    } sync_state_t;

    typedef struct packed {
        logic [12:0] count;
        logic step;
    } div_state_t;

    typedef struct packed {
        logic [7:0] trig_ctrl;
        logic [7:0] gpt_hi;
        logic [7:0] gpt_lo;
        logic [7:0] main_mask;
        logic [7:0] tf_mask;
        gpt_state_t gpt_state;
        logic [15:0] gpt_count;
        logic field_arm;
        logic field_off;
        logic gpt_expire;
        logic [7:0] rdata;
        logic [7:0] main_irq;
        logic [7:0] tf_irq;
        logic irq;
    } top_state_t;

endpackage

// [rtl/carrier_sync.sv]
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser with agreement filter and rising edge pulse
module carrier_sync
    import gpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rise_o
);
    sync_state_t st_r;
    sync_state_t st_nxt;

    // level only moves when stages two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.shift = {st_r.shift[1:0], pin_i};
        st_nxt.rise = 1'b0;
        if (st_r.shift[1] == st_r.shift[2] && st_r.shift[2] != st_r.level) begin
            st_nxt.level = st_r.shift[2];
            st_nxt.rise = st_r.shift[2];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise_o = st_r.rise;
endmodule // carrier_sync
`default_nettype wire

// [rtl/step_divider.sv]
`timescale 1ns/10ps
`default_nettype none
// counts carrier ticks, pulses once every div_i ticks
module step_divider
    import gpt_pkg::*;
#(
    parameter int DW = STEP_DIV_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic [DW-1:0] div_i,
    output logic step_o
);
    div_state_t st_r;
    div_state_t st_nxt;

    if (DW != STEP_DIV_W) begin : g_bad_width
        $error("step_divider width must match the package state width");
    end

    // restart drops a partial step so a new period starts whole
    always_comb begin
        st_nxt = st_r;
        st_nxt.step = 1'b0;
        if (restart_i) begin
            st_nxt.count = '0;
        end else if (tick_i) begin
            if (st_r.count >= div_i - 13'h0001) begin
                st_nxt.count = '0;
                st_nxt.step = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign step_o = st_r.step;
endmodule // step_divider
`default_nettype wire

// [test/gpt_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// port relations of the timer and mask block
module gpt_asserts
    import gpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic rd_i,
    input wire logic set_default_i,
    input wire logic [7:0] main_src_i,
    input wire logic [7:0] tf_src_i,
    input wire logic [7:0] rdata_o,
    input wire logic gpt_running_o,
    input wire logic gpt_expire_o,
    input wire logic field_off_o,
    input wire logic nrt_emv_o,
    input wire logic nrt_step_o,
    input wire logic [7:0] main_irq_o,
    input wire logic [7:0] tf_irq_o,
    input wire logic irq_o
);
    // one domain, so clock and reset are stated once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request needs an unmasked source one cycle before
    chk_main_gate: assert property ((main_irq_o & ~($past(main_src_i) & 8'hfc)) == 8'h00)
        else $error("main request without source");
    chk_tf_gate: assert property ((tf_irq_o & 8'hdf & ~$past(tf_src_i)) == 8'h00)
        else $error("timer field request without source");
    chk_gpe_flag: assert property (tf_irq_o[5] |-> $past(gpt_expire_o))
        else $error("timer flag without expiry");
    chk_irq_merge: assert property (irq_o == (|main_irq_o || |tf_irq_o))
        else $error("request line differs from sources");
    // field switch-off and expiry come together, as pulses
    chk_field_expire: assert property (field_off_o |-> gpt_expire_o && !gpt_running_o)
        else $error("field off outside expiry");
    chk_expire_pulse: assert property (gpt_expire_o |=> !gpt_expire_o)
        else $error("expiry longer than one cycle");
    chk_step_gap: assert property (nrt_step_o |=> !nrt_step_o [*8])
        else $error("response steps too close");
    chk_default_stop: assert property (
        set_default_i |-> ##[1:2] (!gpt_running_o && !nrt_emv_o))
        else $error("set default left state behind");
    // reserved bits read as zero
    chk_rsvd_read: assert property (
        rd_i && addr_i == ADDR_MAIN_MASK |=> rdata_o[1:0] == 2'h0)
        else $error("mask reserved bits not zero");
    chk_ctrl_rsvd: assert property (
        rd_i && addr_i == ADDR_TRIG_CTRL |=> rdata_o[4:2] == 3'h0)
        else $error("control reserved bits not zero");
    cover property (gpt_expire_o && field_off_o);
    cover property (tf_irq_o[5] && irq_o);
    cover property (nrt_step_o);
endmodule // gpt_asserts
bind gp_timer_irq_mask gpt_asserts chk_u (.clk_i, .rst_i, .addr_i, .rd_i, .set_default_i,
    .main_src_i, .tf_src_i, .rdata_o, .gpt_running_o, .gpt_expire_o, .field_off_o, .nrt_emv_o,
    .nrt_step_o, .main_irq_o, .tf_irq_o, .irq_o);
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import gpt_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, set_default_i = 1'b0;
    logic carrier_i = 1'b0, nrt_restart_i = 1'b0, gpt_running_o, gpt_expire_o, field_off_o;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, main_src_i = 8'h00, tf_src_i = 8'h00;
    logic [7:0] rdata_o, main_irq_o, tf_irq_o;
    logic nrt_emv_o, nrt_step_o, irq_o;
    logic [1:0] cdiv = 2'h0;
    timer_ev_t ev_i = '0;
    int err_total = 0, comparisons = 0;
    gp_timer_irq_mask dut_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .set_default_i,
        .carrier_i, .ev_i, .nrt_restart_i, .main_src_i, .tf_src_i, .rdata_o, .gpt_running_o,
        .gpt_expire_o, .field_off_o, .nrt_emv_o, .nrt_step_o, .main_irq_o, .tf_irq_o, .irq_o);
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // carrier of four clocks a period, so every count is exact
    always @(posedge clk_i) begin
        cdiv <= cdiv + 2'h1;
        carrier_i <= cdiv[1];
    end
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        @(posedge clk_i) wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
        @(posedge clk_i) rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask
    task set_def;
        @(posedge clk_i) set_default_i <= 1'b1;
        @(posedge clk_i) set_default_i <= 1'b0;
    endtask
    // pulse bits cleared, the mode level kept
    task automatic pulse_ev(input timer_ev_t e);
        @(posedge clk_i) ev_i <= e;
        @(posedge clk_i) ev_i <= timer_ev_t'({4'h0, e.nfc_mode});
    endtask
    // bounded wait; a hang ends the run
    task automatic wait_for(ref logic s, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (s !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            err_total++;
            $display("wrong value at %0t: wait ran out", $time);
            final_report;
        end
    endtask
    task t_regs;
        logic [7:0] used [5];
        used = '{TRIG_CTRL_USED, 8'hff, 8'hff, MAIN_MASK_USED, 8'hff};
        for (int i = 0; i < 6; i++) rd(ADDR_TRIG_CTRL + 8'(i), 8'h00);
        for (int i = 0; i < 5; i++) wr(ADDR_TRIG_CTRL + 8'(i), 8'hff);
        wr(8'h20, 8'hff);
        for (int i = 0; i < 5; i++) rd(ADDR_TRIG_CTRL + 8'(i), used[i]);
        rd(8'h20, 8'h00);
        chk({7'h0, nrt_emv_o}, 8'h01);
        set_def;
        for (int i = 0; i < 5; i++) rd(ADDR_TRIG_CTRL + 8'(i), 8'h00);
        chk({7'h0, nrt_emv_o}, 8'h00);
        // set-default and a write in one cycle: the default must win
        @(posedge clk_i) {addr_i, wdata_i, wr_i, set_default_i} <= {ADDR_MAIN_MASK, 8'hff, 2'h3};
        @(posedge clk_i) {wr_i, set_default_i} <= 2'h0;
        rd(ADDR_MAIN_MASK, 8'h00);
    endtask
    // every code against every hardware event; tx end outside nfc mode never starts
    task t_trig;
        timer_ev_t evs [4];
        logic hit;
        evs = '{timer_ev_t'(5'h04), timer_ev_t'(5'h08), timer_ev_t'(5'h03), timer_ev_t'(5'h02)};
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 4; k++) begin
                hit = (c == k + 1) && (k < 3);
                set_def;
                wr(ADDR_GPT_LO, 8'h03);
                wr(ADDR_TRIG_CTRL, {3'(c), 5'h00});
                pulse_ev(evs[k]);
                @(posedge clk_i);
                #1 chk({7'h0, gpt_running_o}, {7'h0, hit});
                rd(ADDR_STATUS, {6'h0, hit && k == 2, hit});
            end
        end
    endtask
    task automatic t_gpt(input logic [7:0] hi, lo, tfm, input timer_ev_t e, input logic [2:0] c);
        int n, t;
        set_def;
        wr(ADDR_GPT_HI, hi);
        wr(ADDR_GPT_LO, lo);
        wr(ADDR_TF_MASK, tfm);
        wr(ADDR_TRIG_CTRL, {c, 5'h00});
        pulse_ev(e);
        t = 32 * {hi, lo};
        wait_for(gpt_expire_o, n);
        chk({7'h0, n >= t - 8 && n <= t + 16}, 8'h01);
        chk({7'h0, field_off_o}, {7'h0, c == TRIG_TX_END_NFC});
        @(posedge clk_i);
        #1 chk({6'h0, tf_irq_o[5], irq_o}, {6'h0, {2{~tfm[5]}}});
    endtask
    task automatic t_mask(input logic [7:0] mm, tm, em, et);
        logic [7:0] m, t;
        logic q;
        set_def;
        wr(ADDR_MAIN_MASK, mm);
        wr(ADDR_TF_MASK, tm);
        @(posedge clk_i) {main_src_i, tf_src_i} <= {8'hff, 8'hff};
        @(posedge clk_i) {main_src_i, tf_src_i} <= 16'h0000;
        #1 {m, t, q} = {main_irq_o, tf_irq_o, irq_o};
        @(posedge clk_i);
        #1 {m, t, q} = {m | main_irq_o, t | tf_irq_o, q | irq_o};
        chk(m, em);
        chk(t, et);
        chk({7'h0, q}, {7'h0, |{em, et}});
    endtask
    task automatic t_nrt(input logic step, input int per);
        int n;
        set_def;
        wr(ADDR_TRIG_CTRL, {7'h0, step});
        @(posedge clk_i) nrt_restart_i <= 1'b1;
        @(posedge clk_i) nrt_restart_i <= 1'b0;
        wait_for(nrt_step_o, n);
        wait_for(nrt_step_o, n);
        chk({7'h0, n == per}, 8'h01);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_trig;
        t_gpt(8'h00, 8'h03, 8'h00, timer_ev_t'(5'h10), TRIG_CMD_ONLY);
        t_gpt(8'h01, 8'h00, 8'h20, timer_ev_t'(5'h10), TRIG_CMD_ONLY);
        t_gpt(8'h00, 8'h03, 8'h00, timer_ev_t'(5'h03), TRIG_TX_END_NFC);
        t_mask(8'ha8, 8'h0f, 8'h54, 8'hd0);
        t_mask(8'hff, 8'hff, 8'h00, 8'h00);
        t_nrt(1'b0, 256);
        t_nrt(1'b1, 16384);
        final_report;
    end
endmodule // tb_top
`default_nettype wire
